// *** lma_pkg.sv ***
// Shared constants, command codes and types of the memory addressing block.
package lma_pkg;

  // ************************************************************
  // Geometry and reset values
  // ************************************************************
  localparam int unsigned LMA_ROWS      = 32;
  localparam int unsigned LMA_COLS      = 80;
  localparam int unsigned LMA_PAGES     = 4;
  localparam int unsigned LMA_OWN_LINES = 16;
  localparam int unsigned LMA_DUTY_SHORT = 16;
  localparam logic [6:0]  LMA_COL_LAST  = 7'h4f;
  localparam logic [1:0]  LMA_PAGE_RST  = 2'h3;
  localparam logic [6:0]  LMA_COL_RST   = 7'h00;
  localparam logic [4:0]  LMA_START_RST = 5'h00;
  localparam logic        LMA_DUTY_RST  = 1'b1;

  // ************************************************************
  // Command codes: a byte hits when (byte & mask) == value
  // ************************************************************
  localparam logic [7:0] LMA_START_MASK = 8'he0;
  localparam logic [7:0] LMA_START_VAL  = 8'hc0;
  localparam logic [7:0] LMA_PAGE_MASK  = 8'hfc;
  localparam logic [7:0] LMA_PAGE_VAL   = 8'hb8;
  localparam logic [7:0] LMA_COL_MASK   = 8'h80;
  localparam logic [7:0] LMA_COL_VAL    = 8'h00;
  localparam logic [7:0] LMA_DUTY_MASK  = 8'hfe;
  localparam logic [7:0] LMA_DUTY_VAL   = 8'ha8;

  // Field positions inside a command byte; the busy bit sits in the status byte.
  localparam int unsigned LMA_START_LSB = 0;
  localparam int unsigned LMA_PAGE_LSB  = 0;
  localparam int unsigned LMA_COL_LSB   = 0;
  localparam int unsigned LMA_DUTY_BIT  = 0;
  localparam int unsigned LMA_BUSY_BIT  = 7;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned LMA_CLK_NS       = 100;
  localparam int unsigned LMA_LINE_TIME_NS = 100000;
  localparam int unsigned LMA_LINE_CYC     = (LMA_LINE_TIME_NS + LMA_CLK_NS - 1) / LMA_CLK_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    LMA_BUS_IDLE = 3'b001,
    LMA_BUS_WR   = 3'b010,
    LMA_BUS_RD   = 3'b100
  } lma_bus_e;

  typedef struct packed {
    logic [1:0] page;
    logic [6:0] col;
    logic [7:0] data;
  } lma_wr_s;

  // Decodes one command byte against a mask and a value.
  function automatic logic lma_cmd_hit(input logic [7:0] b, input logic [7:0] m,
                                       input logic [7:0] v);
    lma_cmd_hit = ((b & m) == v);
  endfunction

endpackage

// *** lma_buf2.sv ***
// Small valid/ready buffer that holds pending display memory writes.
`timescale 1ns/1ns
`default_nettype none
module lma_buf2
#(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 2
)
(
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [AW-1:0]    wr_ix_q;
  logic [AW-1:0]    rd_ix_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshake terms; full and empty come straight from the count.
  assign in_ready_o  = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = slot_q[rd_ix_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Entry storage, written at the fill index.
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      slot_q[wr_ix_q] <= in_data_i;
    end
  end

  // Indices and occupancy.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ix_q <= '0;
      rd_ix_q <= '0;
      cnt_q   <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ix_q <= (wr_ix_q == LAST_IX) ? '0 : wr_ix_q + 1'b1;
      end
      if (pop)
      begin
        rd_ix_q <= (rd_ix_q == LAST_IX) ? '0 : rd_ix_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** lma_row_map.sv ***
// Maps a scan line number to a memory row and flags lines driven on chip.
`timescale 1ns/1ns
`default_nettype none
module lma_row_map
(
  // Scan position
  input  wire logic [4:0] start_row_bits_i,
  input  wire logic [4:0] line_i,
  // Result
  output logic [4:0]      row_o,
  output logic            on_chip_o
);

  import lma_pkg::*;

  // The five-bit sum wraps past row 31 back to row 0.
  assign row_o     = start_row_bits_i + line_i;
  // Only the first lines have their own output pins.
  assign on_chip_o = (32'(line_i) < LMA_OWN_LINES);

endmodule
`default_nettype wire

// *** lma_top.sv ***
// Command decoding, address pointers, display memory and line scan.
`timescale 1ns/1ns
`default_nettype none
module lma_top
#(
  parameter int unsigned LINE_CYC  = lma_pkg::LMA_LINE_CYC,
  parameter int unsigned BUF_DEPTH = 2
)
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Host parallel bus, 80-type strobes
  input  wire logic        cd_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  db_i,
  output logic [7:0]       db_o,
  output logic             db_oe_o,
  output logic             wr_ready_o,
  // Display drive
  output logic [15:0]      first_row_driver_line_o,
  output logic [79:0]      seg_o,
  output logic             duty_long_o
);

  import lma_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int unsigned DW = $bits(lma_wr_s);
  localparam logic [15:0] LINE_ONE = 16'h0001;

  lma_bus_e    bus_q;
  logic [7:0]  cmd_q;
  logic        cd_q;
  logic [4:0]  start_q;
  logic [1:0]  page_q;
  logic [6:0]  col_q;
  logic        duty_q;
  logic [7:0]  db_q;
  logic        db_oe_q;
  logic        wr_ready_q;
  logic [7:0]  mem_q [LMA_PAGES][LMA_COLS];
  logic        wr_end;
  logic        cmd_exec;
  logic        dat_exec;
  logic        rd_end;
  logic        col_step;
  lma_wr_s     buf_in;
  lma_wr_s     buf_out;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic        drain;
  logic [15:0] div_q;
  logic        tick;
  logic [4:0]  line_q;
  logic [4:0]  scan_row;
  logic        scan_on_chip;
  logic [79:0] row_bits;
  logic [15:0] com_q;
  logic [79:0] seg_q;

  // ************************************************************
  // Host bus phases
  // ************************************************************

  // A write ends when its strobe returns high; a read likewise.
  assign wr_end   = (bus_q == LMA_BUS_WR) && wr_n_i;
  assign rd_end   = (bus_q == LMA_BUS_RD) && rd_n_i;
  assign cmd_exec = wr_end && !cd_q;
  assign dat_exec = wr_end && cd_q && buf_in_ready;
  assign col_step = dat_exec || (rd_end && cd_q);

  // Tracks the host strobe phase and holds the last byte seen.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_q <= LMA_BUS_IDLE;
      cmd_q <= 8'h00;
      cd_q  <= 1'b0;
    end
    else
    begin
      unique case (bus_q)
        LMA_BUS_IDLE:
        begin
          cd_q <= cd_i;
          if (!wr_n_i && rd_n_i)
          begin
            bus_q <= LMA_BUS_WR;
            cmd_q <= db_i;
          end
          else if (!rd_n_i && wr_n_i)
          begin
            bus_q <= LMA_BUS_RD;
          end
        end
        LMA_BUS_WR:
        begin
          if (wr_n_i)
          begin
            bus_q <= LMA_BUS_IDLE;
          end
          else
          begin
            cmd_q <= db_i;
          end
        end
        LMA_BUS_RD:
        begin
          if (rd_n_i)
          begin
            bus_q <= LMA_BUS_IDLE;
          end
        end
        default:
        begin
          bus_q <= LMA_BUS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Address pointers and duty
  // ************************************************************

  // Commands load pointers; data accesses advance the column.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_q <= LMA_START_RST;
      page_q  <= LMA_PAGE_RST;
      col_q   <= LMA_COL_RST;
      duty_q  <= LMA_DUTY_RST;
    end
    else if (cmd_exec)
    begin
      if (lma_cmd_hit(cmd_q, LMA_START_MASK, LMA_START_VAL))
      begin
        start_q <= cmd_q[LMA_START_LSB +: 5];
      end
      if (lma_cmd_hit(cmd_q, LMA_PAGE_MASK, LMA_PAGE_VAL))
      begin
        page_q <= cmd_q[LMA_PAGE_LSB +: 2];
      end
      if (lma_cmd_hit(cmd_q, LMA_COL_MASK, LMA_COL_VAL))
      begin
        col_q <= cmd_q[LMA_COL_LSB +: 7];
      end
      if (lma_cmd_hit(cmd_q, LMA_DUTY_MASK, LMA_DUTY_VAL))
      begin
        duty_q <= cmd_q[LMA_DUTY_BIT];
      end
    end
    else if (col_step)
    begin
      col_q <= (col_q == LMA_COL_LAST) ? 7'h00 : col_q + 7'h01;
    end
  end

  // ************************************************************
  // Write buffer and display memory
  // ************************************************************

  // Each write carries its own page and column, so later commands are safe.
  assign buf_in.page = page_q;
  assign buf_in.col  = col_q;
  assign buf_in.data = cmd_q;

  // The scan fetch owns the memory on a tick, so draining stalls then.
  assign buf_out_ready = !tick;
  assign drain         = buf_out_valid && buf_out_ready;

  lma_buf2
  #(
    .WIDTH (DW),
    .DEPTH (BUF_DEPTH)
  )
  u_buf
  (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_end && cd_q),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out)
  );

  // Four pages of column bytes; columns past the last are not stored.
  always_ff @(posedge ref_clk_i)
  begin
    if (drain && (buf_out.col <= LMA_COL_LAST))
    begin
      mem_q[buf_out.page][buf_out.col] <= buf_out.data;
    end
  end

  // Read data goes out while the read strobe is low; status shows busy.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      db_q       <= 8'h00;
      db_oe_q    <= 1'b0;
      wr_ready_q <= 1'b0;
    end
    else
    begin
      wr_ready_q <= buf_in_ready;
      if ((bus_q == LMA_BUS_IDLE) && !rd_n_i && wr_n_i)
      begin
        db_oe_q <= 1'b1;
        if (!cd_i)
        begin
          db_q <= 8'(buf_out_valid) << LMA_BUSY_BIT;
        end
        else if (col_q <= LMA_COL_LAST)
        begin
          db_q <= mem_q[page_q][col_q];
        end
        else
        begin
          db_q <= 8'h00;
        end
      end
      else if (rd_n_i)
      begin
        db_oe_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Line scan
  // ************************************************************

  lma_row_map u_map
  (
    .start_row_bits_i (start_q),
    .line_i           (line_q),
    .row_o            (scan_row),
    .on_chip_o        (scan_on_chip)
  );

  // Gathers the row bit of every column: page from the top row bits.
  for (genvar c = 0; c < LMA_COLS; c++)
  begin : g_col
    assign row_bits[c] = mem_q[scan_row[4:3]][c][scan_row[2:0]];
  end

  // Line rate divider.
  assign tick = (32'(div_q) == LINE_CYC - 1);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 16'h0000;
    end
    else
    begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Steps the line through the block length chosen by duty.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_q <= 5'h00;
      com_q  <= 16'h0000;
      seg_q  <= 80'h0;
    end
    else if (tick)
    begin
      com_q  <= scan_on_chip ? (LINE_ONE << line_q[3:0]) : 16'h0000;
      seg_q  <= row_bits;
      if (!duty_q && (32'(line_q) == LMA_DUTY_SHORT - 1))
      begin
        line_q <= 5'h00;
      end
      else
      begin
        line_q <= line_q + 5'h01;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign db_o                    = db_q;
  assign db_oe_o                 = db_oe_q;
  assign wr_ready_o              = wr_ready_q;
  assign first_row_driver_line_o = com_q;
  assign seg_o                   = seg_q;
  assign duty_long_o             = duty_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_start;
    (bus_q == LMA_BUS_IDLE) && !rd_n_i && wr_n_i && cd_i && (col_q <= LMA_COL_LAST);
  endsequence

  start_load_a: assert property (cmd_exec && lma_cmd_hit(cmd_q, LMA_START_MASK, LMA_START_VAL)
    |=> start_q == $past(cmd_q[4:0])) else $error("Start line not loaded.");
  page_load_a: assert property (cmd_exec && lma_cmd_hit(cmd_q, LMA_PAGE_MASK, LMA_PAGE_VAL)
    |=> page_q == $past(cmd_q[1:0])) else $error("Page not loaded.");
  col_load_a: assert property (cmd_exec && !cmd_q[7]
    |=> col_q == $past(cmd_q[6:0])) else $error("Column not loaded.");
  col_inc_a: assert property (col_step && (col_q < LMA_COL_LAST)
    |=> col_q == $past(col_q) + 7'h01) else $error("Column did not advance.");
  col_wrap_a: assert property (col_step && (col_q == LMA_COL_LAST)
    |=> (col_q == 7'h00) && $stable(page_q)) else $error("Column wrap wrong.");
  line_bound_a: assert property (!duty_q && tick && (line_q == 5'h0f)
    |=> line_q == 5'h00) else $error("Short duty line overrun.");
  com_line_a: assert property (tick && (line_q < 5'h10)
    |=> com_q == (LINE_ONE << $past(line_q[3:0]))) else $error("Common line wrong.");
  row_wrap_a: assert property (scan_row == 5'(start_q + line_q))
    else $error("Row mapping wrong.");
  store_a: assert property (drain && (buf_out.col <= LMA_COL_LAST)
    |=> mem_q[$past(buf_out.page)][$past(buf_out.col)] == $past(buf_out.data))
    else $error("Memory write lost.");
  read_data_a: assert property (s_rd_start
    |=> db_oe_o && (db_o == $past(mem_q[page_q][col_q]))) else $error("Read data wrong.");

endmodule
`default_nettype wire

// *** lma_host_model.sv ***
// Host microcontroller model driving the parallel bus of the memory addressing block.
`timescale 1ns/1ns
`default_nettype none
module lma_host_model
(
  // Clock
  input  wire logic       ref_clk_i,
  // Device answers
  input  wire logic [7:0] db_i,
  input  wire logic       db_oe_i,
  input  wire logic       wr_ready_i,
  // Bus drive
  output var logic        cd_o,
  output var logic        rd_n_o,
  output var logic        wr_n_o,
  output var logic [7:0]  db_o,
  output var logic        timeout_o
);
  // Idle bus: both strobes high, no hang seen yet.
  initial
  begin
    cd_o      = 1'b0;
    rd_n_o    = 1'b1;
    wr_n_o    = 1'b1;
    db_o      = 8'h00;
    timeout_o = 1'b0;
  end

  // Writes one byte; a data byte first waits, bounded, for room in the buffer.
  task automatic wr_byte(input logic cd, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    cd_o = cd;
    while (cd && wr_ready_i !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 200)
      timeout_o = 1'b1;
    @(negedge ref_clk_i);
    wr_n_o = 1'b0;
    db_o   = d;
    @(negedge ref_clk_i);
    wr_n_o = 1'b1;
    db_o   = ~d; // Released data shows the inverse so stale values never match.
  endtask

  // Reads one byte; an undriven bus returns unknown so that it cannot pass.
  task automatic rd_byte(input logic cd, output logic [7:0] d);
    @(negedge ref_clk_i);
    cd_o = cd;
    @(negedge ref_clk_i);
    rd_n_o = 1'b0;
    @(negedge ref_clk_i);
    d      = (db_oe_i === 1'b1) ? db_i : 8'hxx;
    rd_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench of the memory addressing block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lma_pkg::*;
  localparam int unsigned LINE_CYC = 4;

  // ************************************************************
  // Wiring
  // ************************************************************
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        cd_i;
  logic        rd_n_i;
  logic        wr_n_i;
  logic [7:0]  db_i;
  logic [7:0]  db_o;
  logic        db_oe_o;
  logic        wr_ready_o;
  logic        hang;
  logic [15:0] com;
  logic [79:0] seg;
  logic        duty_long_o;
  int          errors    = 0;
  int          tests_run = 0;

  lma_top #(.LINE_CYC(LINE_CYC), .BUF_DEPTH(2)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cd_i(cd_i), .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i), .db_i(db_i), .db_o(db_o), .db_oe_o(db_oe_o),
    .wr_ready_o(wr_ready_o), .first_row_driver_line_o(com), .seg_o(seg),
    .duty_long_o(duty_long_o));

  lma_host_model host (
    .ref_clk_i(ref_clk_i), .db_i(db_o), .db_oe_i(db_oe_o), .wr_ready_i(wr_ready_o),
    .cd_o(cd_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .db_o(db_i), .timeout_o(hang));

  // The clock runs at 10 MHz.
  always #50 ref_clk_i = ~ref_clk_i;

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A host that hangs on a full buffer, or a run that overstays, ends the test.
  always @(posedge ref_clk_i)
  begin
    if (hang === 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: write buffer never ready", $time);
      final_report();
    end
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    errors++;
    $display("MISMATCH at %0t: run too long", $time);
    final_report();
  end

  // ************************************************************
  // Bus helpers
  // ************************************************************
  task automatic cmd(input logic [7:0] b);
    host.wr_byte(1'b0, b);
  endtask

  task automatic wrd(input logic [7:0] b);
    host.wr_byte(1'b1, b);
  endtask

  // Waits, bounded, until buffered writes have landed, so reads see fresh data.
  task automatic drain();
    logic [7:0] s;
    int         n;
    s = 8'h80;
    n = 0;
    while (s[7] !== 1'b0 && n < 50)
    begin
      host.rd_byte(1'b0, s);
      n++;
    end
    chk8(s, 8'h00, "status idle");
    // Only a buffer that never empties ends the run here.
    if (s[7] !== 1'b0)
      final_report();
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] d;
    drain();
    host.rd_byte(1'b1, d);
    chk8(d, exp, "memory read");
  endtask

  // Byte of column k in page p: bit b holds bit k of row 8p+b.
  function automatic logic [7:0] row_pat(input int p, input int k);
    logic [7:0] r;
    for (int b = 0; b < 8; b++)
      r[b] = 1'(((8 * p + b) >> k) & 1);
    return r;
  endfunction

  // Watches 40 lines: the driven line must show row start+line, the five
  // pattern columns spelling the row number.
  task automatic scan_chk(input logic [4:0] st, input logic long_exp);
    logic [15:0] seen;
    int          zeros;
    seen  = 16'h0000;
    zeros = 0;
    repeat (33 * LINE_CYC) @(negedge ref_clk_i);
    repeat (40 * LINE_CYC)
    begin
      @(negedge ref_clk_i);
      seen = seen | com;
      if (com === 16'h0000)
        zeros++;
      chk8({7'h00, (com & (com - 16'h0001)) == 16'h0000}, 8'h01, "one line");
      for (int i = 0; i < 16; i++)
        if (com[i] === 1'b1)
          chk8({3'h0, seg[4:0]}, {3'h0, st + 5'(i)}, "row on line");
    end
    chk16(seen, 16'hffff, "all own lines used");
    chk8({7'h00, duty_long_o}, {7'h00, long_exp}, "duty");
    chk8({7'h00, zeros > 0}, {7'h00, long_exp}, "lines off chip");
    $display("test scan start %0d done", st);
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    logic [4:0] starts [4];
    starts = '{5'h02, 5'h11, 5'h1f, 5'h00};
    repeat (20) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    // Reset state: page 3, column 0, full duty.
    @(negedge ref_clk_i);
    chk8({7'h00, duty_long_o}, 8'h01, "duty after reset");
    chk8({7'h00, wr_ready_o}, 8'h01, "ready after reset");
    wrd(8'h3c);
    wrd(8'hc3);
    cmd(8'hbb);
    cmd(8'h00);
    rd_chk(8'h3c);
    rd_chk(8'hc3);
    $display("test reset state done");
    // Every page code, then codes that must be ignored.
    for (int p = 0; p < 4; p++)
    begin
      cmd(8'hb8 | 8'(p));
      cmd(8'h05);
      wrd(8'ha0 | 8'(p));
    end
    cmd(8'hbc);
    cmd(8'h05);
    cmd(8'h80);
    rd_chk(8'ha3);
    for (int p = 0; p < 4; p++)
    begin
      cmd(8'hb8 | 8'(p));
      cmd(8'h05);
      rd_chk(8'ha0 | 8'(p));
    end
    $display("test pages done");
    // Column wrap past 79 keeps the page.
    cmd(8'hb9);
    cmd(8'h4f);
    wrd(8'h11);
    wrd(8'h22);
    wrd(8'h33);
    cmd(8'h4f);
    rd_chk(8'h11);
    rd_chk(8'h22);
    rd_chk(8'h33);
    cmd(8'hb9);
    cmd(8'h00);
    rd_chk(8'h22);
    $display("test column wrap done");
    // Row pattern for the scan, then start lines and duty.
    for (int p = 0; p < 4; p++)
    begin
      cmd(8'hb8 | 8'(p));
      cmd(8'h00);
      for (int k = 0; k < 5; k++)
        wrd(row_pat(p, k));
    end
    drain();
    scan_chk(5'h00, 1'b1);
    foreach (starts[j])
    begin
      cmd(8'hc0 | {3'h0, starts[j]});
      scan_chk(starts[j], 1'b1);
    end
    cmd(8'hc5);
    cmd(8'ha8);
    scan_chk(5'h05, 1'b0);
    // Back to the long block, so the other duty code is exercised too.
    cmd(8'ha9);
    scan_chk(5'h05, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
